//--- inc/safety_input_regs.svh
`ifndef SAFETY_INPUT_REGS_SVH
`define SAFETY_INPUT_REGS_SVH
// Field positions within input byte 0.
`define SIB_RESERVED_BIT 0
`define SIB_ESTOP_BIT 1
`define SIB_OPSAFE_BIT 2
`define SIB_OPACK_BIT 3
`define SIB_STOP1_BIT 4
`define SIB_STOP2_BIT 5
// Timing: clock rate and drives-off delay after safety stop 1.
`define SIB_CLK_HZ 40000000
`define SIB_STOP1_DELAY_MS 1500
`define SIB_STOP1_DELAY_CYC ((`SIB_CLK_HZ / 1000) * `SIB_STOP1_DELAY_MS)
// Reset value of the synchroniser: every function stopped, acknowledgement bit high.
`define SIB_BYTE_RST 8'h08
`endif

//--- inc/safety_input_pkg.sv
package safety_input_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_STOP1 = 2'b10,
    ST_OFF = 2'b11
  } drive_state_t;
endpackage : safety_input_pkg

//--- verilog/safety_input_byte_decoder.sv

`timescale 1ns/1ps
`default_nettype none
`include "safety_input_regs.svh"
module safety_input_byte_decoder #(
  parameter int unsigned STOP1_DELAY_CYC = `SIB_STOP1_DELAY_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Received input byte 0 and configuration.
  input wire logic [7:0] input_byte_in,
  input wire logic reserved_input_assigned_in,
  input wire logic ack_required_in,
  // Decoded status.
  output logic ext_estop_active_out,
  output logic operator_safety_out,
  output logic operator_safety_acked_out,
  output logic servo_hold_out,
  // Enables.
  output logic motion_enable_out,
  output logic drives_enable_out,
  output logic second_supply_switch_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the drives-off timer needs at least one cycle.
  if (STOP1_DELAY_CYC < 1) begin : gen_bad_delay
    $error("STOP1_DELAY_CYC must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motion and the second supply are allowed by the same condition.
  function automatic logic enable_ok(input logic go_ok, input logic s1_n, input logic s2_n);
    return go_ok && s1_n && s2_n;
  endfunction : enable_ok

  ////////////////////////////////////////////////////////////////////////////
  // Registers and next values.
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic ack_prev_r;
  logic acked_r;
  logic [31:0] cnt_r;
  safety_input_pkg::drive_state_t st_r;
  logic motion_r;
  logic drives_r;
  logic supply_r;
  logic estop_r;
  logic opsafe_r;
  logic hold_r;
  logic estop_nxt;
  logic opsafe_nxt;
  logic hold_nxt;
  logic acked_nxt;
  logic [31:0] cnt_nxt;
  safety_input_pkg::drive_state_t st_nxt;
  logic motion_nxt;
  logic drives_nxt;
  logic supply_nxt;
  logic reserved_ok;
  logic estop_n;
  logic opsafe;
  logic stop1_n;
  logic stop2_n;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  // The reset value stops every function, so nothing is enabled before real input arrives.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= `SIB_BYTE_RST;
      sync2_r <= `SIB_BYTE_RST;
    end else begin
      sync1_r <= input_byte_in;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode; bits 6 and 7 are never read.
  always_comb begin
    reserved_ok = !reserved_input_assigned_in || sync2_r[`SIB_RESERVED_BIT];
    estop_n = sync2_r[`SIB_ESTOP_BIT];
    opsafe = sync2_r[`SIB_OPSAFE_BIT];
    stop1_n = sync2_r[`SIB_STOP1_BIT];
    stop2_n = sync2_r[`SIB_STOP2_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operator safety acknowledgement.
  // The previous bit resets high, so a bit held high through reset is no acknowledgement.
  always_comb begin
    acked_nxt = acked_r;
    if (!opsafe) begin
      acked_nxt = 1'b0;
    end else if (!ack_prev_r && sync2_r[`SIB_OPACK_BIT]) begin
      acked_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_prev_r <= 1'b1;
      acked_r <= 1'b0;
    end else begin
      ack_prev_r <= sync2_r[`SIB_OPACK_BIT];
      acked_r <= acked_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable sequencing.
  // Safety stops drop motion and supply at once; stop one drops the drives after the timer, stop two leaves them on.
  always_comb begin
    logic go;
    go = estop_n && opsafe && (acked_r || !ack_required_in) && reserved_ok;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    motion_nxt = enable_ok(go, stop1_n, stop2_n);
    supply_nxt = enable_ok(go, stop1_n, stop2_n);
    drives_nxt = drives_r;
    unique case (st_r)
      safety_input_pkg::ST_IDLE: begin
        st_nxt = safety_input_pkg::ST_RUN;
        drives_nxt = estop_n;
      end
      safety_input_pkg::ST_RUN: begin
        drives_nxt = estop_n;
        if (!estop_n) begin
          st_nxt = safety_input_pkg::ST_OFF;
        end else if (!stop1_n) begin
          st_nxt = safety_input_pkg::ST_STOP1;
          cnt_nxt = 32'h0;
        end
      end
      safety_input_pkg::ST_STOP1: begin
        // Drives stay on while the timer runs and drop once it expires or at once on emergency stop.
        drives_nxt = 1'b1;
        if (!estop_n) begin
          st_nxt = safety_input_pkg::ST_OFF;
          drives_nxt = 1'b0;
        end else if (stop1_n) begin
          st_nxt = safety_input_pkg::ST_RUN;
        end else if (cnt_r >= STOP1_DELAY_CYC - 1) begin
          st_nxt = safety_input_pkg::ST_OFF;
          drives_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      safety_input_pkg::ST_OFF: begin
        // Drives return only once emergency stop and safety stop one are both clear.
        drives_nxt = 1'b0;
        if (estop_n && stop1_n) begin
          st_nxt = safety_input_pkg::ST_RUN;
          drives_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= safety_input_pkg::ST_IDLE;
      cnt_r <= 32'h0;
      motion_r <= 1'b0;
      drives_r <= 1'b0;
      supply_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      motion_r <= motion_nxt;
      drives_r <= drives_nxt;
      supply_r <= supply_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded status flags.
  always_comb begin
    estop_nxt = !estop_n;
    opsafe_nxt = opsafe;
    hold_nxt = drives_nxt && !stop2_n;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      estop_r <= 1'b0;
      opsafe_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      estop_r <= estop_nxt;
      opsafe_r <= opsafe_nxt;
      hold_r <= hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ports come straight from the registers.
  always_comb begin
    ext_estop_active_out = estop_r;
    operator_safety_out = opsafe_r;
    operator_safety_acked_out = acked_r;
    servo_hold_out = hold_r;
    motion_enable_out = motion_r;
    drives_enable_out = drives_r;
    second_supply_switch_out = supply_r;
  end
endmodule : safety_input_byte_decoder
`default_nettype wire

//--- tb/safety_input_byte_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] input_byte_in,
  input wire logic ext_estop_active_out,
  input wire logic operator_safety_out,
  input wire logic operator_safety_acked_out,
  input wire logic servo_hold_out,
  input wire logic motion_enable_out,
  input wire logic drives_enable_out,
  input wire logic second_supply_switch_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence estop_held;
    !input_byte_in[1] [*3];
  endsequence
  chk_estop_drives: assert property (estop_held |=> !drives_enable_out)
    else $error("drives on in estop");
  chk_estop_flag: assert property (estop_held |=> ext_estop_active_out)
    else $error("estop flag low");
  chk_stop1_motion: assert property (!input_byte_in[4] [*3] |=> !motion_enable_out)
    else $error("motion in stop one");
  chk_stop2_motion: assert property (!input_byte_in[5] [*3] |=> !motion_enable_out)
    else $error("motion in stop two");
  chk_supply_follows: assert property (second_supply_switch_out == motion_enable_out)
    else $error("supply differs");
  chk_gate_open: assert property (!input_byte_in[2] [*3] |=> !operator_safety_out)
    else $error("safety high with gate open");
  chk_ack_needs_safe: assert property ($rose(operator_safety_acked_out) |-> operator_safety_out)
    else $error("ack without safety");
  chk_servo_hold: assert property (servo_hold_out |-> drives_enable_out && !motion_enable_out)
    else $error("bad servo hold");
endmodule : decoder_monitor
bind safety_input_byte_decoder decoder_monitor mon_u (.clk_in(clk_in), .rstn_in(rstn_in),
  .input_byte_in(input_byte_in), .ext_estop_active_out(ext_estop_active_out),
  .operator_safety_out(operator_safety_out),
  .operator_safety_acked_out(operator_safety_acked_out), .servo_hold_out(servo_hold_out),
  .motion_enable_out(motion_enable_out), .drives_enable_out(drives_enable_out),
  .second_supply_switch_out(second_supply_switch_out));
`default_nettype wire

//--- tb/safety_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module safety_plc_model (
  input wire logic clk_in,
  input wire logic [7:0] cmd_in,
  input wire logic res_low_in,
  output logic [7:0] byte_out
);
  always_ff @(posedge clk_in) byte_out <= {cmd_in[7:1], !res_low_in};
endmodule : safety_plc_model
`default_nettype wire

//--- tb/test_safety_input_byte_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_safety_input_byte_decoder;
  logic clk_in = 0, rstn_in = 0, res_low = 0, reserved_input_assigned_in = 0;
  logic ack_required_in = 1'h0;
  logic [7:0] cmd = 8'hf6, input_byte_in;
  logic ext_estop_active_out, operator_safety_out, operator_safety_acked_out, servo_hold_out;
  logic motion_enable_out, drives_enable_out, second_supply_switch_out;
  wire logic [6:0] o = {motion_enable_out, second_supply_switch_out, drives_enable_out,
    ext_estop_active_out, servo_hold_out, operator_safety_out, operator_safety_acked_out};
  int err_total = 0, checks = 0;
  always #12.5 clk_in = ~clk_in;
  safety_plc_model plc_u (.clk_in(clk_in), .cmd_in(cmd), .res_low_in(res_low),
    .byte_out(input_byte_in));
  safety_input_byte_decoder #(.STOP1_DELAY_CYC(20)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .input_byte_in(input_byte_in), .reserved_input_assigned_in(reserved_input_assigned_in),
    .ack_required_in(ack_required_in), .ext_estop_active_out(ext_estop_active_out),
    .operator_safety_out(operator_safety_out),
    .operator_safety_acked_out(operator_safety_acked_out), .servo_hold_out(servo_hold_out),
    .motion_enable_out(motion_enable_out), .drives_enable_out(drives_enable_out),
    .second_supply_switch_out(second_supply_switch_out));
  task automatic check_val(input logic [6:0] seen, input logic [6:0] want);
    checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: outputs %h want %h", $time, seen, want);
    end
  endtask : check_val
  task automatic step(input logic r, input logic a, input logic [7:0] v, input int n,
      input logic [6:0] m, input logic [6:0] e);
    res_low <= r;
    reserved_input_assigned_in <= a;
    cmd <= v;
    repeat (n - 1) @(posedge clk_in);
    @(negedge clk_in);
    check_val(o & m, e);
    @(posedge clk_in);
  endtask : step
  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1;
    step(1'h0, 1'h0, 8'hf6, 8, 7'h7f, 7'h72);
    step(1'h1, 1'h0, 8'hf6, 8, 7'h70, 7'h70);
    step(1'h1, 1'h1, 8'hf6, 8, 7'h60, 7'h00);
    step(1'h0, 1'h0, 8'hf4, 8, 7'h58, 7'h08);
    step(1'h0, 1'h0, 8'hf6, 10, 7'h18, 7'h10);
    step(1'h0, 1'h0, 8'hd6, 8, 7'h74, 7'h14);
    step(1'h0, 1'h0, 8'hf6, 8, 7'h60, 7'h60);
    step(1'h0, 1'h0, 8'he6, 8, 7'h70, 7'h10);
    step(1'h0, 1'h0, 8'he6, 16, 7'h10, 7'h10);
    step(1'h0, 1'h0, 8'he6, 8, 7'h10, 7'h00);
    step(1'h0, 1'h0, 8'hf6, 8, 7'h50, 7'h50);
    step(1'h0, 1'h0, 8'h36, 8, 7'h70, 7'h70);
    step(1'h0, 1'h0, 8'hf2, 8, 7'h03, 7'h00);
    step(1'h0, 1'h0, 8'hfa, 8, 7'h03, 7'h00);
    step(1'h0, 1'h0, 8'hf2, 4, 7'h01, 7'h00);
    step(1'h0, 1'h0, 8'hf6, 8, 7'h03, 7'h02);
    step(1'h0, 1'h0, 8'hfe, 8, 7'h03, 7'h03);
    ack_required_in <= 1'h1;
    step(1'h0, 1'h0, 8'hf2, 8, 7'h43, 7'h00);
    step(1'h0, 1'h0, 8'hf6, 8, 7'h43, 7'h02);
    step(1'h0, 1'h0, 8'hfe, 8, 7'h43, 7'h43);
    final_report();
  end
endmodule : test_safety_input_byte_decoder
`default_nettype wire
